/* verilog/scm_pkg.sv */
// constants for the smart card status and master control block
package scm_pkg;
   // -----------------------------------------------------------------
   // register byte addresses (index times four)
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_LINE_STATUS = 8'h05;
   localparam logic [7:0] IDX_MASTER_CTRL = 8'h06;
   localparam logic [11:0] ADDR_LINE_STATUS = {2'h0, IDX_LINE_STATUS, 2'h0};
   localparam logic [11:0] ADDR_MASTER_CTRL = {2'h0, IDX_MASTER_CTRL, 2'h0};
   localparam logic [11:0] ADDR_PATH_CTRL = 12'h040;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h044;
   localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h048;
   localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h04C;
   // -----------------------------------------------------------------
   // master control fields
   // -----------------------------------------------------------------
   localparam int BMC_SOFT_RESET = 0;
   localparam int BMC_IRQ_MASTER = 1;
   // -----------------------------------------------------------------
   // path control fields
   // -----------------------------------------------------------------
   localparam int PC_RX_PATH = 0;
   localparam int PC_TX_PATH = 1;
   localparam int PC_AUTO_DEACT = 2;
   localparam int PC_T0_MODE = 3;
   // -----------------------------------------------------------------
   // interrupt status bits
   // -----------------------------------------------------------------
   localparam int IRQ_W = 6;
   localparam int IRQ_PARITY = 0;
   localparam int IRQ_FRAMING = 1;
   localparam int IRQ_OVERRUN = 2;
   localparam int IRQ_UNDERFLOW = 3;
   localparam int IRQ_TX_FAIL = 4;
   localparam int IRQ_TX_DONE = 5;
   // -----------------------------------------------------------------
   // reset values and timing
   // -----------------------------------------------------------------
   localparam logic [3:0] PATH_CTRL_RST = 4'h3;
   localparam logic RST_TX_EMPTY = 1'b1;
   localparam logic [2:0] SOFT_RESET_CYCLES = 3'h4;
endpackage : scm_pkg

/* verilog/scm_status_ctrl.sv */
// line status, master control and interrupt logic of the smart card block
// Operation
// - bit 7 records parity error phase
// - tx empty clears on start, sets after guard
// - bit 5 sets on guard time failure
// - empty fifo read sets underflow, drops rx path
// - framing error after store, drops rx path
// - parity error sets bit 2, drops path
// - parity error deactivates card when enabled
// - lost character sets overrun, drops rx path
// - truncated transmit message gives no overrun
// - bit 0 shows received data, read-stable
// - line status read clears bits 7 to 1
// - master enable zero blocks every interrupt
// - soft reset keeps configuration, clears gpio irqs
// - soft reset bit self-clears when done
// - card deactivation only in T=0 mode
`timescale 1ns/1ps
`default_nettype none
module scm_status_ctrl
   import scm_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [11:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   // events from the transfer logic
   input wire logic i_tx_start,
   input wire logic i_tx_done,
   input wire logic i_guard_fail,
   input wire logic i_fifo_rd,
   input wire logic i_fifo_empty,
   input wire logic i_rx_frame_err,
   input wire logic i_par_err,
   input wire logic i_par_rx,
   input wire logic i_rx_lost,
   input wire logic i_tx_truncated,
   input wire logic i_rx_data_avail,
   // controls to the rest of the block
   output logic o_rx_fifo_path_enable,
   output logic o_tx_fifo_path_enable,
   output logic o_card_deactivate,
   output logic o_block_reset,
   output logic o_gpio_irq_clear,
   output logic o_irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic par_phase;
      logic tx_empty;
      logic tx_fail;
      logic underflow;
      logic framing;
      logic parity;
      logic overrun;
      logic rx_path;
      logic tx_path;
      logic auto_deact;
      logic t0_mode;
      logic irq_master;
      logic [IRQ_W-1:0] irq_sts;
      logic [IRQ_W-1:0] irq_en;
      logic soft_rst;
      logic [2:0] rst_cnt;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
      logic deact;
      logic gpio_clr;
   } scm_state_t;

   scm_state_t q;
   scm_state_t d;
   logic acc;
   logic rd_lsr;
   logic ev_any;
   logic [7:0] lsr_val;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // every transfer is zero wait state, so the address phase is taken
   // whenever the bus is ready
   // hsize is not decoded: every register is one aligned word, so a
   // narrower access behaves as a whole-word one
   assign acc = i_hsel & i_htrans[1] & i_hready;
   assign rd_lsr = acc & ~i_hwrite & (i_haddr == ADDR_LINE_STATUS);
   assign ev_any = i_tx_done | i_tx_start | i_guard_fail | i_rx_frame_err
                   | i_par_err | i_rx_lost | (i_fifo_rd & i_fifo_empty);

   // line status image, bit 0 is live fifo state
   assign lsr_val = {q.par_phase, q.tx_empty, q.tx_fail, q.underflow,
                     q.framing, q.parity, q.overrun, i_rx_data_avail};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.deact = 1'b0;
      d.gpio_clr = 1'b0;
      d.wr_pend = acc & i_hwrite;
      d.wr_addr = i_haddr;
      // write data phase; the line status register ignores writes
      if (q.wr_pend) begin
         unique case (q.wr_addr)
            ADDR_MASTER_CTRL: begin
               d.irq_master = i_hwdata[BMC_IRQ_MASTER];
               // writing zero to the reset bit has no effect
               if (i_hwdata[BMC_SOFT_RESET] && !q.soft_rst) begin
                  d.soft_rst = 1'b1;
                  d.rst_cnt = SOFT_RESET_CYCLES;
                  d.gpio_clr = 1'b1;
               end
            end
            ADDR_PATH_CTRL: begin
               d.rx_path = i_hwdata[PC_RX_PATH];
               d.tx_path = i_hwdata[PC_TX_PATH];
               d.auto_deact = i_hwdata[PC_AUTO_DEACT];
               d.t0_mode = i_hwdata[PC_T0_MODE];
            end
            ADDR_IRQ_CLEAR: begin
               d.irq_sts = q.irq_sts & ~i_hwdata[IRQ_W-1:0];
            end
            ADDR_IRQ_ENABLE: begin
               d.irq_en = i_hwdata[IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // read address phase; data is captured before the clear
      if (acc && !i_hwrite) begin
         unique case (i_haddr)
            ADDR_LINE_STATUS: d.rdata = {24'h000000, lsr_val};
            // master control bits 7 to 2 have no storage behind them
            ADDR_MASTER_CTRL: d.rdata = {30'h0, q.irq_master,
                                         q.soft_rst};
            ADDR_PATH_CTRL: d.rdata = {28'h0000000, q.t0_mode, q.auto_deact,
                                       q.tx_path, q.rx_path};
            ADDR_IRQ_STATUS: d.rdata = {26'h0, q.irq_sts};
            ADDR_IRQ_ENABLE: d.rdata = {26'h0, q.irq_en};
            default: d.rdata = 32'h00000000;
         endcase
      end
      // clear on read of everything but the live data bit
      // read data was latched from q above, so the old flags still return
      if (rd_lsr) begin
         d.par_phase = 1'b0;
         d.tx_empty = 1'b0;
         d.tx_fail = 1'b0;
         d.underflow = 1'b0;
         d.framing = 1'b0;
         d.parity = 1'b0;
         d.overrun = 1'b0;
      end
      // hardware events come last so a set beats a same-cycle clear
      if (!q.soft_rst) begin
         if (i_guard_fail) begin
            d.tx_fail = 1'b1;
            d.irq_sts[IRQ_TX_FAIL] = 1'b1;
         end
         if (i_fifo_rd && i_fifo_empty) begin
            d.underflow = 1'b1;
            d.rx_path = 1'b0;
            d.irq_sts[IRQ_UNDERFLOW] = 1'b1;
         end
         // the event pulse comes once the faulty character is stored
         if (i_rx_frame_err) begin
            d.framing = 1'b1;
            d.rx_path = 1'b0;
            d.irq_sts[IRQ_FRAMING] = 1'b1;
         end
         if (i_par_err) begin
            d.parity = 1'b1;
            d.par_phase = i_par_rx;
            d.irq_sts[IRQ_PARITY] = 1'b1;
            if (i_par_rx) begin
               d.rx_path = 1'b0;
            end else begin
               d.tx_path = 1'b0;
            end
            // the card is dropped at once, outside software control
            d.deact = q.auto_deact & q.t0_mode;
         end
         // a truncated transmit message sets nothing at all
         if (i_rx_lost) begin
            d.overrun = 1'b1;
            d.rx_path = 1'b0;
            d.irq_sts[IRQ_OVERRUN] = 1'b1;
         end
         if (i_tx_start) begin
            d.tx_empty = 1'b0;
         end
         // done wins over a start in the same cycle
         if (i_tx_done) begin
            d.tx_empty = 1'b1;
            d.irq_sts[IRQ_TX_DONE] = 1'b1;
         end
      end else begin
         // block reset: status returns to idle, configuration stays
         // events arriving now are dropped, the block is not yet usable
         d.par_phase = 1'b0;
         d.tx_empty = RST_TX_EMPTY;
         d.tx_fail = 1'b0;
         d.underflow = 1'b0;
         d.framing = 1'b0;
         d.parity = 1'b0;
         d.overrun = 1'b0;
         d.irq_sts = '0;
         d.rst_cnt = q.rst_cnt - 3'h1;
         if (q.rst_cnt == 3'h1) begin
            d.soft_rst = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         q <= '0;
         q.tx_empty <= RST_TX_EMPTY;
         q.rx_path <= PATH_CTRL_RST[PC_RX_PATH];
         q.tx_path <= PATH_CTRL_RST[PC_TX_PATH];
         q.auto_deact <= PATH_CTRL_RST[PC_AUTO_DEACT];
         q.t0_mode <= PATH_CTRL_RST[PC_T0_MODE];
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_hrdata = q.rdata;
   assign o_rx_fifo_path_enable = q.rx_path;
   assign o_tx_fifo_path_enable = q.tx_path;
   assign o_card_deactivate = q.deact;
   assign o_block_reset = q.soft_rst;
   assign o_gpio_irq_clear = q.gpio_clr;
   // master enable gates the whole request
   assign o_irq = q.irq_master & |(q.irq_sts & q.irq_en);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_reset);

   AST_PHASE: assert property (i_par_err && !q.soft_rst |=>
      q.par_phase == $past(i_par_rx))
      else $error("parity phase not recorded");
   AST_TXE_CLR: assert property (i_tx_start && !i_tx_done && !q.soft_rst
      |=> !q.tx_empty)
      else $error("tx empty not cleared at start");
   AST_TXE_SET: assert property (i_tx_done && !q.soft_rst |=> q.tx_empty)
      else $error("tx empty not set at done");
   AST_TX_FAIL: assert property (i_guard_fail && !q.soft_rst
      |=> q.tx_fail && q.irq_sts[IRQ_TX_FAIL])
      else $error("guard failure not flagged");
   AST_UFLOW: assert property (i_fifo_rd && i_fifo_empty && !q.soft_rst
      |=> q.underflow && !o_rx_fifo_path_enable)
      else $error("underflow not handled");
   AST_FRAME: assert property (i_rx_frame_err && !q.soft_rst
      |=> q.framing && !o_rx_fifo_path_enable)
      else $error("framing error not handled");
   AST_PAR_PATH: assert property (i_par_err && !q.soft_rst |=> q.parity
      && ($past(i_par_rx) ? !o_rx_fifo_path_enable : !o_tx_fifo_path_enable))
      else $error("parity error path not dropped");
   AST_DEACT: assert property (i_par_err && !q.soft_rst && q.auto_deact
      && q.t0_mode |=> o_card_deactivate ##1 !o_card_deactivate)
      else $error("card not deactivated");
   AST_T0_ONLY: assert property (o_card_deactivate |->
      $past(q.t0_mode) && $past(q.auto_deact) && $past(i_par_err))
      else $error("deactivation outside t0 mode");
   AST_OVERRUN: assert property (i_rx_lost && !q.soft_rst
      |=> q.overrun && !o_rx_fifo_path_enable)
      else $error("overrun not handled");
   AST_TRUNC: assert property (i_tx_truncated && !i_rx_lost && !q.overrun
      |=> !q.overrun)
      else $error("truncation raised overrun");
   AST_DRDY: assert property (rd_lsr |=>
      o_hrdata[0] == $past(i_rx_data_avail))
      else $error("data ready bit wrong");
   AST_RDCLR: assert property (rd_lsr && !ev_any && !q.soft_rst
      |=> {q.par_phase, q.tx_empty, q.tx_fail, q.underflow, q.framing,
           q.parity, q.overrun} == 7'h00)
      else $error("status not cleared by read");
   AST_GIE: assert property (!q.irq_master |-> !o_irq)
      else $error("interrupt while master enable off");
   AST_GPIO_CLR: assert property ($rose(q.soft_rst) |-> o_gpio_irq_clear
      && $stable(q.irq_en) && ($stable(q.rx_path) || $past(ev_any)))
      else $error("soft reset touched configuration");
   AST_SRST_END: assert property ($rose(q.soft_rst) |->
      q.soft_rst[*4] ##1 !q.soft_rst)
      else $error("soft reset did not self clear");
   AST_RSV: assert property (acc && !i_hwrite && i_haddr == ADDR_MASTER_CTRL
      |=> o_hrdata[31:2] == 30'h0)
      else $error("reserved bits not zero");

   // ----------------------------------------------------------------
   // assertions on side effects, interrupts and soft reset
   // ----------------------------------------------------------------
   // a hardware event beats a clear by read in the same cycle
   AST_RD_SET_WINS: assert property (rd_lsr && i_guard_fail && !q.soft_rst
      |=> q.tx_fail)
      else $error("read clear beat guard failure");
   AST_TRUNC_PATH: assert property (i_tx_truncated && !ev_any && !q.wr_pend
      |=> $stable(q.rx_path) && $stable(q.tx_path))
      else $error("truncation touched a fifo path");

   // every error also raises its sticky interrupt status bit
   AST_PAR_IRQ: assert property (i_par_err && !q.soft_rst
      |=> q.irq_sts[IRQ_PARITY])
      else $error("parity interrupt not raised");
   AST_FRAME_IRQ: assert property (i_rx_frame_err && !q.soft_rst
      |=> q.irq_sts[IRQ_FRAMING])
      else $error("framing interrupt not raised");
   AST_UFLOW_IRQ: assert property (i_fifo_rd && i_fifo_empty && !q.soft_rst
      |=> q.irq_sts[IRQ_UNDERFLOW])
      else $error("underflow interrupt not raised");
   AST_OVR_IRQ: assert property (i_rx_lost && !q.soft_rst
      |=> q.irq_sts[IRQ_OVERRUN])
      else $error("overrun interrupt not raised");
   AST_DONE_IRQ: assert property (i_tx_done && !q.soft_rst
      |=> q.irq_sts[IRQ_TX_DONE])
      else $error("transmit done interrupt not raised");

   // register side: read data holds, writes land, clears obey software
   AST_RD_HOLD: assert property (!(acc && !i_hwrite)
      |=> $stable(o_hrdata))
      else $error("read data moved without a read");
   AST_GIE_WR: assert property (q.wr_pend && q.wr_addr == ADDR_MASTER_CTRL
      |=> q.irq_master == $past(i_hwdata[BMC_IRQ_MASTER]))
      else $error("master enable write lost");
   AST_IRQ_CLR_WR: assert property (q.wr_pend && q.wr_addr == ADDR_IRQ_CLEAR && !ev_any
      |=> (q.irq_sts & $past(i_hwdata[IRQ_W-1:0])) == '0)
      else $error("interrupt status not cleared");
   AST_PATH_WR: assert property (q.wr_pend && q.wr_addr == ADDR_PATH_CTRL && !ev_any
      |=> o_rx_fifo_path_enable == $past(i_hwdata[PC_RX_PATH])
      && o_tx_fifo_path_enable == $past(i_hwdata[PC_TX_PATH]))
      else $error("path control write lost");

   // soft reset: flags to idle, configuration and enables held
   AST_SRST_CLR: assert property (q.soft_rst
      |=> q.irq_sts == '0 && q.tx_empty && !q.parity && !q.framing && !q.overrun)
      else $error("soft reset left status set");
   AST_CFG_HOLD: assert property (q.soft_rst && !q.wr_pend
      |=> $stable({q.rx_path, q.tx_path, q.auto_deact, q.t0_mode})
      && $stable(q.irq_en) && $stable(q.irq_master))
      else $error("soft reset changed configuration");
   AST_GPIO_PULSE: assert property (o_gpio_irq_clear |=> !o_gpio_irq_clear)
      else $error("gpio clear longer than one cycle");
   AST_SRST_NODEACT: assert property (q.soft_rst && i_par_err
      |=> !o_card_deactivate)
      else $error("card dropped during soft reset");

endmodule : scm_status_ctrl
`default_nettype wire

/* dv/scm_card_model.sv */
// card-side model that turns bench requests into transfer events
`timescale 1ns/1ps
`default_nettype none
module scm_card_model (
   input wire logic i_sys_clk,
   input wire logic [8:0] i_req,
   input wire logic i_par_rx_req,
   input wire logic i_avail_req,
   output logic [8:0] o_ev,
   output logic o_par_rx,
   output logic o_avail
);
   // ------------------------------------------------------------
   // event pulses
   // ------------------------------------------------------------
   // one-cycle request becomes a one-cycle pulse; faults come after the char is stored
   always_ff @(posedge i_sys_clk) begin
      o_ev <= i_req;
      o_par_rx <= i_par_rx_req;
      o_avail <= i_avail_req;
   end
endmodule : scm_card_model
`default_nettype wire

/* dv/scm_status_ctrl_bench.sv */
// self-checking bench for the status and master control block
`timescale 1ns/1ps
`default_nettype none
module scm_status_ctrl_bench
   import scm_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [8:0] req = 9'h000;
   logic prx = 1'b0;
   logic avail = 1'b0;
   wire logic hrdy, hresp, rxp, txp, deact, brst, gclr, irq, par_rx, av;
   wire logic [31:0] hrdata;
   wire logic [8:0] ev;
   logic [63:0] exp_q[$];
   logic rd_dp = 1'b0;
   int err_total = 0;
   int checked = 0;
   int n_deact = 0;
   int n_gclr = 0;
   int n_rst = 0;
   initial forever #2.5 clk = ~clk;
   scm_card_model scm_card_model_inst (.i_sys_clk(clk), .i_req(req), .i_par_rx_req(prx),
      .i_avail_req(avail), .o_ev(ev), .o_par_rx(par_rx), .o_avail(av));
   scm_status_ctrl scm_status_ctrl_inst (.i_sys_clk(clk), .i_reset(rst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp),
      .o_hrdata(hrdata), .i_tx_start(ev[0]), .i_tx_done(ev[1]), .i_guard_fail(ev[2]),
      .i_fifo_rd(ev[3]), .i_fifo_empty(ev[4]), .i_rx_frame_err(ev[5]), .i_par_err(ev[6]),
      .i_par_rx(par_rx), .i_rx_lost(ev[7]), .i_tx_truncated(ev[8]), .i_rx_data_avail(av),
      .o_rx_fifo_path_enable(rxp), .o_tx_fifo_path_enable(txp), .o_card_deactivate(deact),
      .o_block_reset(brst), .o_gpio_irq_clear(gclr), .o_irq(irq));
   // ------------------------------------------------------------
   // compare and finish
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // irq is sampled mid-cycle, clear of the edge that updates it
   task automatic chk_irq(input logic [31:0] e);
      @(negedge clk);
      chk(32'(irq), e);
   endtask : chk_irq
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   // read data is judged at the data-phase end edge, oldest note first
   always @(posedge clk) begin
      if (rd_dp) begin
         chk(32'(hresp), 32'h0);
         if (exp_q.size() != 0) begin
            logic [63:0] n;
            n = exp_q.pop_front();
            chk(hrdata & n[63:32], n[31:0]);
         end
      end
      rd_dp = hsel & htrans[1] & hrdy & !hwrite & !rst;
      if (deact === 1'b1) n_deact++;
      if (gclr === 1'b1) n_gclr++;
      if (brst === 1'b1) n_rst++;
   end
   // ------------------------------------------------------------
   // bus and event drivers
   // ------------------------------------------------------------
   // waits on hready for as long as it takes; only the watchdog ends a hang
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      if (!w) exp_q.push_back({m, e});
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
   endtask : bus
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 32'hFFFFFFFF, e);
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0, 32'h0);
   endtask : wr
   task automatic evt(input logic [8:0] r, input logic p);
      @(posedge clk);
      req <= r;
      prx <= p;
      @(posedge clk);
      req <= 9'h000;
      repeat (3) @(posedge clk);
   endtask : evt
   initial begin
      #100000;
      err_total++;
      $display("watchdog expired");
      test_done();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      logic [8:0] rq[8] = '{9'h004, 9'h018, 9'h008, 9'h020, 9'h040, 9'h040, 9'h080, 9'h100};
      logic [7:0] ls[8] = '{8'h20, 8'h10, 8'h00, 8'h08, 8'h84, 8'h04, 8'h02, 8'h00};
      logic [1:0] pe[8] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h2, 2'h1, 2'h2, 2'h3};
      logic [31:0] r;
      int n;
      void'($urandom(32'h9592));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_LINE_STATUS, 32'h40);
      rd(ADDR_MASTER_CTRL, 32'h0);
      rd(ADDR_PATH_CTRL, 32'h3);
      rd(12'h100, 32'h0);
      avail <= 1'b1;
      rd(ADDR_LINE_STATUS, 32'h01);
      rd(ADDR_LINE_STATUS, 32'h01);
      avail <= 1'b0;
      $display("test reset and read-clear done");
      // each fault once, parity once in each phase, with the fifo paths re-armed before it
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_PATH_CTRL, 32'h3);
         evt(rq[i], i == 4);
         chk(32'({txp, rxp}), 32'(pe[i]));
         rd(ADDR_LINE_STATUS, 32'(ls[i]));
      end
      $display("test fault flags done");
      evt(9'h002, 1'b0);
      evt(9'h001, 1'b0);
      rd(ADDR_LINE_STATUS, 32'h00);
      evt(9'h003, 1'b0);
      rd(ADDR_LINE_STATUS, 32'h40);
      $display("test transmit empty done");
      wr(ADDR_PATH_CTRL, 32'h7);
      evt(9'h040, 1'b1);
      chk(32'(n_deact), 32'h0);
      wr(ADDR_PATH_CTRL, 32'hF);
      evt(9'h040, 1'b1);
      chk(32'(n_deact), 32'h1);
      rd(ADDR_LINE_STATUS, 32'h84);
      $display("test deactivation done");
      wr(ADDR_IRQ_CLEAR, 32'h3F);
      rd(ADDR_IRQ_STATUS, 32'h0);
      r = $urandom();
      wr(ADDR_IRQ_ENABLE, r);
      rd(ADDR_IRQ_ENABLE, r & 32'h3F);
      wr(ADDR_IRQ_ENABLE, 32'h3F);
      evt(9'h020, 1'b0);
      chk_irq(32'h0);
      rd(ADDR_IRQ_STATUS, 32'h02);
      wr(ADDR_MASTER_CTRL, 32'h2);
      chk_irq(32'h1);
      wr(ADDR_IRQ_ENABLE, 32'h3D);
      chk_irq(32'h0);
      wr(ADDR_IRQ_ENABLE, 32'h3F);
      chk_irq(32'h1);
      wr(ADDR_IRQ_CLEAR, 32'h02);
      chk_irq(32'h0);
      $display("test interrupts done");
      evt(9'h024, 1'b0);
      n_rst = 0;
      wr(ADDR_MASTER_CTRL, 32'hFF);
      n = 0;
      do begin
         bus(1'b0, ADDR_MASTER_CTRL, 32'h0, 32'h0, 32'h0);
         n++;
      end while (hrdata[BMC_SOFT_RESET] !== 1'b0 && n < 20);
      chk(32'(n < 20), 32'h1);
      rd(ADDR_MASTER_CTRL, 32'h2);
      chk(32'(n_rst), 32'(SOFT_RESET_CYCLES));
      chk(32'(n_gclr), 32'h1);
      rd(ADDR_PATH_CTRL, 32'hE);
      rd(ADDR_IRQ_ENABLE, 32'h3F);
      rd(ADDR_IRQ_STATUS, 32'h0);
      rd(ADDR_LINE_STATUS, 32'h40);
      $display("test soft reset done");
      test_done();
   end
endmodule : scm_status_ctrl_bench
`default_nettype wire
